// ---- include/ssalu_pkg.sv ----
// Constants and types shared by the subtract and shift-subtract datapath
package ssalu_pkg;
  localparam int ACC_W = 56;
  localparam int LONG_W = 48;
  localparam int WORD_W = 24;
  localparam int IMM_W = 6;
  localparam int WORD_LSB = 24;
  localparam int SIGN_BIT = 47;
  // Condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_U = 4;
  localparam int CC_E = 5;
  localparam int CC_L = 6;
  localparam int CC_S = 7;
  localparam logic [7:0] CCR_RST = 8'h00;
  // Opcode fields
  localparam int DEST_BIT = 3;
  localparam logic [2:0] TAIL_SUB = 3'h4;
  localparam logic [2:0] TAIL_SHIFT = 3'h6;
  localparam logic [3:0] HEAD_SHIFT_LEFT_SUBTRACT_OP = 4'h1;
  localparam logic [3:0] HEAD_SHIFT_RIGHT_SUBTRACT_OP = 4'h0;
  localparam logic [3:0] HEAD_IMM_S = 4'h8;
  localparam logic [3:0] HEAD_IMM_L = 4'hc;
  localparam logic [9:0] HIGH_IMM_S = 10'h005;
  localparam logic [15:0] HIGH_IMM_L = 16'h0140;
  // Source select codes
  localparam logic [2:0] SRC_ACC = 3'h1;
  localparam logic [2:0] SRC_X = 3'h2;
  localparam logic [2:0] SRC_Y = 3'h3;
  localparam logic [2:0] SRC_X0 = 3'h4;
  localparam logic [2:0] SRC_Y0 = 3'h5;
  localparam logic [2:0] SRC_X1 = 3'h6;
  localparam logic [2:0] SRC_Y1 = 3'h7;
  // Scaling modes
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;
  typedef enum logic [2:0] {
    SSALU_NONE,
    SSALU_SUB_REG,
    SSALU_SUB_IMM,
    SSALU_SHIFT_LEFT_SUBTRACT_OP,
    SSALU_SHIFT_RIGHT_SUBTRACT_OP
  } ssalu_op_e;
endpackage : ssalu_pkg

// ---- design/ssalu_top.sv ----
// Subtract, shift-left-subtract and shift-right-subtract datapath with condition codes

module ssalu_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Instruction from the decoder
  input wire logic op_valid,
  input wire logic [23:0] op_word,
  input wire logic [23:0] ext_word,
  // Data ALU register file
  input wire logic [55:0] acc_a,
  input wire logic [55:0] acc_b,
  input wire logic [23:0] x0,
  input wire logic [23:0] x1,
  input wire logic [23:0] y0,
  input wire logic [23:0] y1,
  input wire logic [1:0] scale_mode,
  // Condition code load from the core
  input wire logic ccr_wr,
  input wire logic [7:0] ccr_wdata,
  // Write-back
  output logic acc_wr_en_ff,
  output logic acc_wr_sel_ff,
  output logic [55:0] acc_wr_data_ff,
  output logic [7:0] condition_code_reg_ff,
  output logic op_reject_ff
);

  function automatic logic [55:0] word_align(input logic [23:0] w);
    word_align = {{8{w[23]}}, w, 24'h000000};
  endfunction : word_align

  function automatic logic [55:0] long_align(input logic [47:0] l);
    long_align = {{8{l[47]}}, l};
  endfunction : long_align

  ssalu_pkg::ssalu_op_e op_kind;
  logic dest_sel;
  logic [2:0] source_select_field;
  logic [55:0] dest_val;
  logic [55:0] other_val;
  logic [55:0] src_val;
  logic [55:0] opnd_val;
  logic [56:0] diff;
  logic [55:0] res;
  logic v_sub;
  logic v_shift;
  logic [7:0] nxt_ccr;
  logic [7:0] ccr_base;

  assign dest_sel = op_word[ssalu_pkg::DEST_BIT];
  assign source_select_field = op_word[6:4];
  assign dest_val = dest_sel ? acc_b : acc_a;
  assign other_val = dest_sel ? acc_a : acc_b;

  // Decode and source alignment
  always_comb begin
    op_kind = ssalu_pkg::SSALU_NONE;
    src_val = 56'h0;
    if (op_word[2:0] == ssalu_pkg::TAIL_SHIFT && op_word[7:4] == ssalu_pkg::HEAD_SHIFT_LEFT_SUBTRACT_OP) begin
      op_kind = ssalu_pkg::SSALU_SHIFT_LEFT_SUBTRACT_OP;
      src_val = other_val;
    end else if (op_word[2:0] == ssalu_pkg::TAIL_SHIFT &&
                 op_word[7:4] == ssalu_pkg::HEAD_SHIFT_RIGHT_SUBTRACT_OP) begin
      op_kind = ssalu_pkg::SSALU_SHIFT_RIGHT_SUBTRACT_OP;
      src_val = other_val;
    end else if (op_word[2:0] == ssalu_pkg::TAIL_SUB && op_word[7:4] == ssalu_pkg::HEAD_IMM_S &&
                 op_word[23:14] == ssalu_pkg::HIGH_IMM_S) begin
      op_kind = ssalu_pkg::SSALU_SUB_IMM;
      src_val = {26'h0, op_word[13:8], 24'h000000};
    end else if (op_word[2:0] == ssalu_pkg::TAIL_SUB && op_word[7:4] == ssalu_pkg::HEAD_IMM_L &&
                 op_word[23:8] == ssalu_pkg::HIGH_IMM_L) begin
      op_kind = ssalu_pkg::SSALU_SUB_IMM;
      src_val = word_align(ext_word);
    end else if (op_word[2:0] == ssalu_pkg::TAIL_SUB && !op_word[7]) begin
      op_kind = ssalu_pkg::SSALU_SUB_REG;
      case (source_select_field)
        ssalu_pkg::SRC_ACC: src_val = other_val;
        ssalu_pkg::SRC_X: src_val = long_align({x1, x0});
        ssalu_pkg::SRC_Y: src_val = long_align({y1, y0});
        ssalu_pkg::SRC_X0: src_val = word_align(x0);
        ssalu_pkg::SRC_Y0: src_val = word_align(y0);
        ssalu_pkg::SRC_X1: src_val = word_align(x1);
        ssalu_pkg::SRC_Y1: src_val = word_align(y1);
        default: op_kind = ssalu_pkg::SSALU_NONE;
      endcase
    end
  end

  // Preliminary shift of the destination
  always_comb begin
    case (op_kind)
      ssalu_pkg::SSALU_SHIFT_LEFT_SUBTRACT_OP: opnd_val = {dest_val[54:0], 1'b0};
      ssalu_pkg::SSALU_SHIFT_RIGHT_SUBTRACT_OP: opnd_val = {dest_val[55], dest_val[55:1]};
      default: opnd_val = dest_val;
    endcase
  end

  // Full 56-bit subtraction; the borrow out of bit 55 is the carry
  assign diff = {1'b0, opnd_val} - {1'b0, src_val};
  assign res = diff[55:0];
  assign v_sub = (opnd_val[55] ^ src_val[55]) & (opnd_val[55] ^ res[55]);
  assign v_shift = (op_kind == ssalu_pkg::SSALU_SHIFT_LEFT_SUBTRACT_OP) && (dest_val[55] ^ dest_val[54]);

  // Flags; sticky bits keep a set that arrives with a core load
  always_comb begin
    ccr_base = ccr_wr ? ccr_wdata : condition_code_reg_ff;
    nxt_ccr = ccr_base;
    if (op_kind != ssalu_pkg::SSALU_NONE && op_valid) begin
      nxt_ccr[ssalu_pkg::CC_C] = diff[56];
      nxt_ccr[ssalu_pkg::CC_V] = v_sub | v_shift;
      nxt_ccr[ssalu_pkg::CC_Z] = (res == 56'h0);
      nxt_ccr[ssalu_pkg::CC_N] = res[55];
      nxt_ccr[ssalu_pkg::CC_L] = ccr_base[ssalu_pkg::CC_L] | v_sub | v_shift;
      case (scale_mode)
        ssalu_pkg::SCALE_DOWN: begin
          nxt_ccr[ssalu_pkg::CC_E] = !((&res[55:48]) || !(|res[55:48]));
          nxt_ccr[ssalu_pkg::CC_U] = !(res[48] ^ res[47]);
          nxt_ccr[ssalu_pkg::CC_S] = ccr_base[ssalu_pkg::CC_S] | (res[47] ^ res[46]);
        end
        ssalu_pkg::SCALE_UP: begin
          nxt_ccr[ssalu_pkg::CC_E] = !((&res[55:46]) || !(|res[55:46]));
          nxt_ccr[ssalu_pkg::CC_U] = !(res[46] ^ res[45]);
          nxt_ccr[ssalu_pkg::CC_S] = ccr_base[ssalu_pkg::CC_S] | (res[45] ^ res[44]);
        end
        default: begin
          nxt_ccr[ssalu_pkg::CC_E] = !((&res[55:47]) || !(|res[55:47]));
          nxt_ccr[ssalu_pkg::CC_U] = !(res[47] ^ res[46]);
          nxt_ccr[ssalu_pkg::CC_S] = ccr_base[ssalu_pkg::CC_S] | (res[46] ^ res[45]);
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      condition_code_reg_ff <= ssalu_pkg::CCR_RST;
    end else begin
      condition_code_reg_ff <= nxt_ccr;
    end
  end

  // Write-back to the selected accumulator
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_wr_en_ff <= 1'b0;
      acc_wr_sel_ff <= 1'b0;
      acc_wr_data_ff <= 56'h0;
      op_reject_ff <= 1'b0;
    end else begin
      acc_wr_en_ff <= op_valid && (op_kind != ssalu_pkg::SSALU_NONE);
      op_reject_ff <= op_valid && (op_kind == ssalu_pkg::SSALU_NONE);
      if (op_valid && op_kind != ssalu_pkg::SSALU_NONE) begin
        acc_wr_sel_ff <= dest_sel;
        acc_wr_data_ff <= res;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_sub_word_x0: assert property (
    op_valid && op_word[7:0] == 8'h44 |=>
      acc_wr_en_ff && !acc_wr_sel_ff &&
      acc_wr_data_ff == $past(acc_a) - {{8{$past(x0[23])}}, $past(x0), 24'h000000})
    else $error("word subtract result wrong");

  a_short_imm_value: assert property (
    op_valid && op_word[23:14] == 10'h005 && op_word[7:0] == 8'h8c |=>
      acc_wr_sel_ff && acc_wr_data_ff == $past(acc_b) - {26'h0, $past(op_word[13:8]), 24'h000000})
    else $error("short immediate subtract wrong");

  a_long_imm_value: assert property (
    op_valid && op_word == 24'h0140c4 |=>
      acc_wr_data_ff == $past(acc_a) - {{8{$past(ext_word[23])}}, $past(ext_word), 24'h000000})
    else $error("long immediate subtract wrong");

  a_acc_carry_exact: assert property (
    op_valid && op_word[7:0] == 8'h14 |=>
      condition_code_reg_ff[0] == ($past(acc_a) < $past(acc_b)))
    else $error("accumulator source carry wrong");

  a_shift_left_subtract_op_shift_ovf: assert property (
    op_valid && op_word[7:0] == 8'h16 && (acc_a[55] != acc_a[54]) |=>
      condition_code_reg_ff[1] && condition_code_reg_ff[6])
    else $error("shift-left overflow not flagged");

  a_shift_left_subtract_op_result: assert property (
    op_valid && op_word[7:0] == 8'h1e |=>
      acc_wr_sel_ff && acc_wr_data_ff == (($past(acc_b) << 1) - $past(acc_a)))
    else $error("shift-left subtract result wrong");

  a_shift_right_subtract_op_result: assert property (
    op_valid && op_word[7:0] == 8'h06 |=>
      acc_wr_data_ff == ({$past(acc_a[55]), $past(acc_a[55:1])} - $past(acc_b)))
    else $error("shift-right subtract result wrong");

  a_shift_right_subtract_op_no_shift_ovf: assert property (
    op_valid && op_word[7:0] == 8'h06 && acc_a[55] == acc_b[55] |=>
      !condition_code_reg_ff[1])
    else $error("shift-right overflow from shift");

  a_zero_neg_flags: assert property (
    acc_wr_en_ff |-> condition_code_reg_ff[2] == (acc_wr_data_ff == 56'h0) &&
      condition_code_reg_ff[3] == acc_wr_data_ff[55])
    else $error("zero or negative flag wrong");

  a_no_spurious_write: assert property (
    !op_valid |=> !acc_wr_en_ff && !op_reject_ff)
    else $error("write without instruction");

  a_reject_keeps_flags: assert property (
    op_valid && op_word[7:0] == 8'h04 && !ccr_wr |=>
      op_reject_ff && !acc_wr_en_ff && $stable(condition_code_reg_ff))
    else $error("rejected opcode changed state");

  // Source alignment and destination checks
  a_long_src_x: assert property (
    op_valid && op_word[7:0] == 8'h24 |=>
      acc_wr_data_ff == $past(acc_a) - {{8{$past(x1[23])}}, $past(x1), $past(x0)})
    else $error("long X subtract result wrong");

  a_long_src_y: assert property (
    op_valid && op_word[7:0] == 8'h34 |=>
      acc_wr_data_ff == $past(acc_a) - {{8{$past(y1[23])}}, $past(y1), $past(y0)})
    else $error("long Y subtract result wrong");

  a_word_x1_to_a: assert property (
    op_valid && op_word[7:0] == 8'h64 |=>
      !acc_wr_sel_ff &&
      acc_wr_data_ff == $past(acc_a) - {{8{$past(x1[23])}}, $past(x1), 24'h000000})
    else $error("word X1 subtract result wrong");

  a_word_y1_to_b: assert property (
    op_valid && op_word[7:0] == 8'h7c |=>
      acc_wr_sel_ff &&
      acc_wr_data_ff == $past(acc_b) - {{8{$past(y1[23])}}, $past(y1), 24'h000000})
    else $error("word Y1 subtract result wrong");

  a_acc_carry_to_b: assert property (
    op_valid && op_word[7:0] == 8'h1c |=>
      condition_code_reg_ff[0] == ($past(acc_b) < $past(acc_a)))
    else $error("accumulator source carry into B wrong");

  a_dest_sel_b: assert property (
    op_valid && op_word[7:0] == 8'h2c |=> acc_wr_en_ff && acc_wr_sel_ff)
    else $error("destination B not selected");

  a_short_imm_taken: assert property (
    op_valid && op_word[23:14] == 10'h005 && op_word[7:4] == 4'h8 && op_word[2:0] == 3'h4 |=>
      acc_wr_en_ff && !op_reject_ff)
    else $error("short immediate not executed");

  a_shift_left_subtract_op_carry_exact: assert property (
    op_valid && op_word[7:0] == 8'h16 && acc_a[55] == acc_a[54] |=>
      condition_code_reg_ff[0] == ({$past(acc_a[54:0]), 1'b0} < $past(acc_b)))
    else $error("shift-left carry wrong");

  a_shift_right_subtract_op_carry_exact: assert property (
    op_valid && op_word[7:0] == 8'h06 |=>
      condition_code_reg_ff[0] == ({$past(acc_a[55]), $past(acc_a[55:1])} < $past(acc_b)))
    else $error("shift-right carry wrong");

  a_shift_right_subtract_op_dest_b: assert property (
    op_valid && op_word[7:0] == 8'h0e |=>
      acc_wr_sel_ff &&
      acc_wr_data_ff == ({$past(acc_b[55]), $past(acc_b[55:1])} - $past(acc_a)))
    else $error("shift-right subtract into B wrong");

  // Flag checks
  a_limit_follows_ovf: assert property (
    acc_wr_en_ff && condition_code_reg_ff[1] |-> condition_code_reg_ff[6])
    else $error("limit flag not set on overflow");

  a_limit_sticky: assert property (
    !ccr_wr && condition_code_reg_ff[6] |=> condition_code_reg_ff[6])
    else $error("limit flag cleared by an operation");

  a_scale_bit_sticky: assert property (
    !ccr_wr && condition_code_reg_ff[7] |=> condition_code_reg_ff[7])
    else $error("scaling flag cleared by an operation");

  a_ext_flag_none: assert property (
    acc_wr_en_ff && $past(scale_mode) == 2'h0 |->
      condition_code_reg_ff[5] == !((&acc_wr_data_ff[55:47]) || !(|acc_wr_data_ff[55:47])))
    else $error("extension flag wrong");

  a_unnorm_flag_none: assert property (
    acc_wr_en_ff && $past(scale_mode) == 2'h0 |->
      condition_code_reg_ff[4] == !(acc_wr_data_ff[47] ^ acc_wr_data_ff[46]))
    else $error("unnormalized flag wrong");

endmodule : ssalu_top

// ---- testbench/ssalu_rf_model.sv ----
// Accumulator register file model on the far side of the datapath
module ssalu_rf_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Bench preload
  input wire logic ld,
  input wire logic [55:0] ld_a,
  input wire logic [55:0] ld_b,
  // Write-back from the datapath
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic [55:0] wr_data,
  // Accumulators
  output logic [55:0] acc_a_ff,
  output logic [55:0] acc_b_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_a_ff <= 56'h0;
      acc_b_ff <= 56'h0;
    end else if (ld) begin
      acc_a_ff <= ld_a;
      acc_b_ff <= ld_b;
    end else if (wr_en && !wr_sel) begin
      acc_a_ff <= wr_data;
    end else if (wr_en) begin
      acc_b_ff <= wr_data;
    end
  end
endmodule : ssalu_rf_model

// ---- testbench/tb.sv ----
// Self-checking bench for the subtract datapath
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [23:0] op_word = 24'h0;
  logic [23:0] ext_word = 24'h0;
  logic [23:0] x0 = 24'h000001;
  logic [23:0] x1 = 24'h800000;
  logic [23:0] y0 = 24'h7fffff;
  logic [23:0] y1 = 24'h000010;
  logic ccr_wr = 1'b0;
  logic [7:0] ccr_wdata = 8'h00;
  logic ld = 1'b0;
  logic [55:0] ld_a = 56'h0;
  logic [55:0] ld_b = 56'h0;
  logic [55:0] acc_a, acc_b, wr_data, exp_a, exp_b;
  logic wr_en, wr_sel, op_reject;
  logic [7:0] condition_code_reg, ccr_old;
  logic [1:0] scale_mode = 2'h0;
  logic [7:0] exp_ccr = 8'h00;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  ssalu_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_word(op_word), .ext_word(ext_word), .acc_a(acc_a), .acc_b(acc_b), .x0(x0),
    .x1(x1), .y0(y0), .y1(y1), .scale_mode(scale_mode), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wdata),
    .acc_wr_en_ff(wr_en), .acc_wr_sel_ff(wr_sel), .acc_wr_data_ff(wr_data),
    .condition_code_reg_ff(condition_code_reg), .op_reject_ff(op_reject));
  ssalu_rf_model i_rf (.ref_clk(ref_clk), .arst_n(arst_n), .ld(ld), .ld_a(ld_a),
    .ld_b(ld_b), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .acc_a_ff(acc_a),
    .acc_b_ff(acc_b));
  task automatic print_verdict();
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  // Returns N, Z, V, C over the 56-bit result
  function automatic logic [59:0] calc(input int kind, input logic [55:0] d,
    input logic [55:0] s);
    logic [55:0] dd;
    logic [56:0] r;
    logic v;
    dd = (kind == 1) ? {d[54:0], 1'b0} : (kind == 2) ? {d[55], d[55:1]} : d;
    r = {1'b0, dd} - {1'b0, s};
    v = ((dd[55] ^ s[55]) & (r[55] ^ dd[55])) | ((kind == 1) & (d[55] ^ d[54]));
    return {r[55], r[55:0] == 56'h0, v, r[56], r[55:0]};
  endfunction : calc
  // Expected flags: E, U and S move with the scaling mode, L and S are sticky
  function automatic logic [7:0] flags(input logic [1:0] sm, input logic [59:0] x);
    int m;
    logic e;
    m = (sm == 2'h1) ? 48 : (sm == 2'h2) ? 46 : 47;
    e = 1'b0;
    for (int i = m; i < 55; i++) begin
      e = e | (x[i] ^ x[i + 1]);
    end
    return {exp_ccr[7] | (x[m - 1] ^ x[m - 2]), exp_ccr[6] | x[57], e, ~(x[m] ^ x[m - 1]),
      x[59:56]};
  endfunction : flags
  function automatic logic [55:0] wsx(input logic [23:0] w);
    return {{8{w[23]}}, w, 24'h0};
  endfunction : wsx
  function automatic logic [55:0] src(input int j, input int d);
    case (j)
      1: return (d == 1) ? exp_a : exp_b;
      2: return {{8{x1[23]}}, x1, x0};
      3: return {{8{y1[23]}}, y1, y0};
      4: return wsx(x0);
      5: return wsx(y0);
      6: return wsx(x1);
      default: return wsx(y1);
    endcase
  endfunction : src
  task automatic load(input logic [55:0] a, input logic [55:0] b);
    @(negedge ref_clk);
    ld = 1'b1;
    ld_a = a;
    ld_b = b;
    exp_a = a;
    exp_b = b;
    @(negedge ref_clk);
    ld = 1'b0;
  endtask : load
  task automatic run(input int kind, input logic [23:0] op, input logic [23:0] e,
    input logic [55:0] s);
    logic [59:0] x;
    logic [7:0] f;
    x = calc(kind, op[3] ? exp_b : exp_a, s);
    f = flags(scale_mode, x);
    @(negedge ref_clk);
    chk(acc_a === exp_a && acc_b === exp_b, "write-back target");
    op_valid = 1'b1;
    op_word = op;
    ext_word = e;
    @(negedge ref_clk);
    op_valid = 1'b0;
    chk(wr_en === 1'b1 && wr_sel === op[3] && op_reject === 1'b0, "strobe or select");
    chk(wr_data === x[55:0], "result");
    chk(condition_code_reg === f, "flags");
    if (op[3]) exp_b = x[55:0];
    else exp_a = x[55:0];
    exp_ccr = f;
  endtask : run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    chk(wr_en === 1'b0 && condition_code_reg === 8'h00 && op_reject === 1'b0, "reset values");
    ccr_wr = 1'b1;
    ccr_wdata = 8'h0f;
    @(negedge ref_clk);
    ccr_wr = 1'b0;
    chk(condition_code_reg === 8'h0f, "flag load");
    exp_ccr = 8'h0f;
    load(56'h00_123456_000000, 56'hff_876543_000000);
    for (int j = 1; j < 8; j++) begin
      for (int d = 0; d < 2; d++) begin
        run(0, {17'h0, j[2:0], d[0], 3'h4}, 24'h0, src(j, d));
      end
    end
    for (int d = 0; d < 2; d++) begin
      scale_mode = d[0] ? 2'h2 : 2'h1;
      run(0, {10'h005, 6'h3f, 4'h8, d[0], 3'h4}, 24'h0, {26'h0, 6'h3f, 24'h0});
      run(0, {16'h0140, 4'hc, d[0], 3'h4}, 24'h800001, wsx(24'h800001));
    end
    scale_mode = 2'h0;
    load(56'h40_000000_000000, 56'h00_000001_000000);
    for (int d = 0; d < 2; d++) begin
      run(1, {16'h0, 4'h1, d[0], 3'h6}, 24'h0, (d == 1) ? exp_a : exp_b);
    end
    load(56'h40_000000_000000, 56'hc0_000001_000000);
    for (int d = 0; d < 2; d++) begin
      run(2, {16'h0, 4'h0, d[0], 3'h6}, 24'h0, (d == 1) ? exp_a : exp_b);
    end
    load(56'h10_000000_000000, 56'h08_000000_000000);
    run(1, 24'h000016, 24'h0, exp_b);
    run(2, 24'h000006, 24'h0, exp_b);
    @(negedge ref_clk);
    chk(acc_a === exp_a && acc_b === exp_b, "write-back target");
    ccr_old = condition_code_reg;
    op_valid = 1'b1;
    op_word = 24'h000004;
    @(negedge ref_clk);
    op_valid = 1'b0;
    chk(op_reject === 1'b1 && wr_en === 1'b0 && condition_code_reg === ccr_old, "reject");
    print_verdict();
  end
endmodule : tb
